/* hw/hs_cfg.svh */
// Constants for the modem-line handshake block
`ifndef HS_CFG_SVH
`define HS_CFG_SVH
`define ADDR_CTRL      4'h0
`define ADDR_LINE_SET  4'h1
`define ADDR_STATUS    4'h2
`define ADDR_IRQ_STAT  4'h3
`define ADDR_IRQ_MASK  4'h4
`define ADDR_WAIT_T    4'h5
`define ADDR_RTSOFF_T  4'h6
`define CTRL_AUTO      0
`define CTRL_HALF      1
`define CTRL_FLOW_LO   2
`define CTRL_FLOW_HI   3
`define CTRL_RX_EN     4
`define SET_DTR        0
`define SET_RTS        1
`define SET_DTR_EN     2
`define SET_RTS_EN     3
`define EV_TX_DONE     0
`define EV_TX_ERR      1
`define EV_DSR_LOST    2
`define EV_REJECT      3
`define EV_RX_DROP     4
`define EV_W           5
`define TICK_NS        1000
`define CLK_NS         8
`define TICK_CYC       (`TICK_NS / `CLK_NS)
`define TIMER_RST      16'h000A
`endif

/* hw/hs_pkg.sv */
// Types for the modem-line handshake block
package hs_pkg;
  typedef enum logic [1:0] {
    FLOW_NONE = 2'h0,
    FLOW_XON  = 2'h1,
    FLOW_RTS  = 2'h2,
    FLOW_RSVD = 2'h3
  } flow_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WAIT = 5'h02,
    ST_SEND = 5'h04,
    ST_HOLD = 5'h08,
    ST_MAN  = 5'h10
  } tx_state_t;
endpackage

/* hw/hs_tick.sv */
// Tick divider: one-cycle enable each period
`timescale 1ns/10ps
module hs_tick #(
  parameter int DIV = 125
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  output logic      tick_o
);
  initial if (DIV < 1) $error("DIV must be at least 1");
  logic [15:0] cnt_reg, cnt_next;
  logic        tick_reg, tick_next;
  always_comb begin
    tick_next = (cnt_reg == 16'(DIV - 1));
    cnt_next  = tick_next ? 16'h0000 : cnt_reg + 16'h0001;
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end
  assign tick_o = tick_reg;
endmodule

/* hw/hs_sync.sv */
// Two-flop synchroniser, one per bit
`timescale 1ns/10ps
module hs_sync #(
  parameter int W = 4
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  initial if (W < 1) $error("W must be at least 1");
  logic [W-1:0] s1_reg, s2_reg;
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
          s1_reg[g] <= 1'b0;
          s2_reg[g] <= 1'b0;
        end else begin
          s1_reg[g] <= d_i[g];
          s2_reg[g] <= s1_reg[g];
        end
      end
    end
  endgenerate
  assign q_o = s2_reg;
endmodule

/* hw/hs_ctrl.sv */
// Modem-line handshake controller with register port
//
// Function
// - RTS and DTR stay inactive after reset until configured or written.
// - Automatic mode works only when half-duplex is configured.
// - Host line writes are refused while automatic mode is active.
// - Entering automatic mode drives RTS off and DTR on.
// - A transmit request raises RTS and loads the output-wait timer.
// - Data shifting starts once the wait expires with CTS on.
// - CTS off at wait end or during send aborts with error.
// - After last character, RTS drops after release delay, ignoring CTS.
// - In automatic mode reception is accepted only while DSR is on.
// - Near-full receive buffer gets no response to the remote.
// - In automatic mode, DSR falling aborts transfers, raises error, logs DSR-lost entry.
// - Host can read DCD, DTR, DSR, RTS, CTS and RI any time.
`timescale 1ns/10ps
`include "hs_cfg.svh"
module hs_ctrl #(
  parameter int TW = 16
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  input  wire logic [3:0]    addr_i,
  input  wire logic [15:0]   wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [15:0]   rdata_o,
  input  wire logic          dcd_i,
  input  wire logic          dsr_i,
  input  wire logic          cts_i,
  input  wire logic          ri_i,
  output logic               rts_o,
  output logic               dtr_o,
  input  wire logic          tx_req_i,
  input  wire logic          tx_last_i,
  output logic               tx_go_o,
  output logic               tx_abort_o,
  input  wire logic          rx_valid_i,
  input  wire logic          rx_near_full_i,
  output logic               rx_accept_o,
  output logic               rx_abort_o,
  output logic               diag_dsr_lost_o,
  output logic               irq_o
);
  import hs_pkg::*;
  initial if (TW < 2 || TW > 16) $error("TW must be 2..16");

  // ***********************************************
  // Synchronised line inputs and tick
  // ***********************************************
  logic [3:0] line_s;
  logic       tick;
  logic       dcd_s, dsr_s, cts_s, ri_s;
  hs_sync #(.W(4)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .d_i       ({ri_i, cts_i, dsr_i, dcd_i}),
    .q_o       (line_s)
  );
  hs_tick #(.DIV(`TICK_CYC)) u_tick (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (tick)
  );
  assign dcd_s = line_s[0];
  assign dsr_s = line_s[1];
  assign cts_s = line_s[2];
  assign ri_s  = line_s[3];

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  // ***********************************************
  // Registers and handshake state
  // ***********************************************
  logic [4:0]        ctrl_reg, ctrl_next;
  logic [TW-1:0]     wait_t_reg, wait_t_next;
  logic [TW-1:0]     rtsoff_t_reg, rtsoff_t_next;
  logic [`EV_W-1:0]  ist_reg, ist_next;
  logic [`EV_W-1:0]  imask_reg, imask_next;
  logic [15:0]       rdata_reg, rdata_next;
  logic              rts_reg, rts_next;
  logic              dtr_reg, dtr_next;
  logic              go_reg, go_next;
  logic              txab_reg, txab_next;
  logic              rxacc_reg, rxacc_next;
  logic              rxab_reg, rxab_next;
  logic              diag_reg, diag_next;
  logic              irq_reg, irq_next;
  logic              dsr_d_reg, dsr_d_next;
  logic              auto_d_reg, auto_d_next;
  logic              rx_busy_reg, rx_busy_next;
  logic [TW-1:0]     tmr_reg, tmr_next;
  tx_state_t         st_reg, st_next;

  logic              auto_on;
  logic              dsr_fall;
  flow_t             flow;
  logic [`EV_W-1:0]  ev;

  always_comb begin
    auto_on  = ctrl_reg[`CTRL_AUTO] & ctrl_reg[`CTRL_HALF];
    flow     = flow_t'(ctrl_reg[`CTRL_FLOW_HI:`CTRL_FLOW_LO]);
    dsr_fall = dsr_d_reg & ~dsr_s;
  end

  always_comb begin
    ctrl_next     = ctrl_reg;
    wait_t_next   = wait_t_reg;
    rtsoff_t_next = rtsoff_t_reg;
    imask_next    = imask_reg;
    rts_next      = rts_reg;
    dtr_next      = dtr_reg;
    st_next       = st_reg;
    tmr_next      = tmr_reg;
    go_next       = 1'b0;
    txab_next     = 1'b0;
    rxab_next     = 1'b0;
    diag_next     = 1'b0;
    rx_busy_next  = rx_busy_reg;
    ev            = '0;
    dsr_d_next    = dsr_s;
    auto_d_next   = auto_on;

    // Host register writes
    if (wr_i) begin
      if (hit(addr_i, `ADDR_CTRL))
        ctrl_next = wdata_i[4:0];
      if (hit(addr_i, `ADDR_WAIT_T))
        wait_t_next = wdata_i[TW-1:0];
      if (hit(addr_i, `ADDR_RTSOFF_T))
        rtsoff_t_next = wdata_i[TW-1:0];
      if (hit(addr_i, `ADDR_IRQ_MASK))
        imask_next = wdata_i[`EV_W-1:0];
      if (hit(addr_i, `ADDR_LINE_SET)) begin
        if (auto_on) begin
          ev[`EV_REJECT] = 1'b1;
        end else begin
          if (wdata_i[`SET_DTR_EN] && flow != FLOW_RSVD)
            dtr_next = wdata_i[`SET_DTR];
          if (wdata_i[`SET_RTS_EN] && (flow == FLOW_NONE || flow == FLOW_XON))
            rts_next = wdata_i[`SET_RTS];
          if (wdata_i[`SET_RTS_EN] && !(flow == FLOW_NONE || flow == FLOW_XON))
            ev[`EV_REJECT] = 1'b1;
        end
      end
    end

    // Mode entry and exit
    if (auto_on && !auto_d_reg) begin
      rts_next = 1'b0;
      dtr_next = 1'b1;
      st_next  = ST_IDLE;
    end else if (!auto_on) begin
      st_next = ST_MAN;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (tx_req_i) begin
            rts_next = 1'b1;
            tmr_next = wait_t_reg;
            st_next  = ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (tmr_reg != '0) begin
            if (tick)
              tmr_next = tmr_reg - 1'b1;
          end else if (cts_s) begin
            go_next = 1'b1;
            st_next = ST_SEND;
          end else begin
            txab_next         = 1'b1;
            ev[`EV_TX_ERR]    = 1'b1;
            rts_next          = 1'b0;
            st_next           = ST_IDLE;
          end
        end
        ST_SEND: begin
          go_next = 1'b1;
          if (!cts_s) begin
            go_next        = 1'b0;
            txab_next      = 1'b1;
            ev[`EV_TX_ERR] = 1'b1;
            rts_next       = 1'b0;
            st_next        = ST_IDLE;
          end else if (tx_last_i) begin
            go_next  = 1'b0;
            tmr_next = rtsoff_t_reg;
            st_next  = ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (tmr_reg == '0) begin
            rts_next        = 1'b0;
            ev[`EV_TX_DONE] = 1'b1;
            st_next         = ST_IDLE;
          end else if (tick) begin
            tmr_next = tmr_reg - 1'b1;
          end
        end
        ST_MAN:  st_next = ST_IDLE;
        default: st_next = ST_IDLE;
      endcase
      if (dsr_fall) begin
        diag_next         = 1'b1;
        ev[`EV_DSR_LOST]  = 1'b1;
        rxab_next         = rx_busy_reg;
        if (st_reg == ST_WAIT || st_reg == ST_SEND || st_reg == ST_HOLD) begin
          txab_next = 1'b1;
          go_next   = 1'b0;
          rts_next  = 1'b0;
          st_next   = ST_IDLE;
        end
      end
    end

    // Receive gating
    rxacc_next = rx_valid_i & ctrl_reg[`CTRL_RX_EN] & ~rx_near_full_i
                 & (~auto_on | dsr_s);
    if (rx_valid_i && !rxacc_next)
      ev[`EV_RX_DROP] = 1'b1;
    if (rxacc_next)
      rx_busy_next = 1'b1;
    if (!rx_valid_i || (auto_on && dsr_fall))
      rx_busy_next = 1'b0;

    // Sticky status, set beats clear
    ist_next = ist_reg;
    if (wr_i && hit(addr_i, `ADDR_IRQ_STAT))
      ist_next = ist_reg & ~wdata_i[`EV_W-1:0];
    ist_next = ist_next | ev;
    irq_next = |(ist_next & imask_next);

    // Read data, one cycle later
    rdata_next = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        `ADDR_CTRL:     rdata_next = {11'h000, ctrl_reg};
        `ADDR_STATUS:   rdata_next = {5'h00, st_reg, ri_s, cts_s, rts_reg,
                                      dsr_s, dtr_reg, dcd_s};
        `ADDR_IRQ_STAT: rdata_next = {11'h000, ist_reg};
        `ADDR_IRQ_MASK: rdata_next = {11'h000, imask_reg};
        `ADDR_WAIT_T:   rdata_next = 16'(wait_t_reg);
        `ADDR_RTSOFF_T: rdata_next = 16'(rtsoff_t_reg);
        default:        rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_reg     <= 5'h00;
      wait_t_reg   <= TW'(`TIMER_RST);
      rtsoff_t_reg <= TW'(`TIMER_RST);
      ist_reg      <= '0;
      imask_reg    <= '0;
      rdata_reg    <= 16'h0000;
      rts_reg      <= 1'b0;
      dtr_reg      <= 1'b0;
      go_reg       <= 1'b0;
      txab_reg     <= 1'b0;
      rxacc_reg    <= 1'b0;
      rxab_reg     <= 1'b0;
      diag_reg     <= 1'b0;
      irq_reg      <= 1'b0;
      dsr_d_reg    <= 1'b0;
      auto_d_reg   <= 1'b0;
      rx_busy_reg  <= 1'b0;
      tmr_reg      <= '0;
      st_reg       <= ST_MAN;
    end else begin
      ctrl_reg     <= ctrl_next;
      wait_t_reg   <= wait_t_next;
      rtsoff_t_reg <= rtsoff_t_next;
      ist_reg      <= ist_next;
      imask_reg    <= imask_next;
      rdata_reg    <= rdata_next;
      rts_reg      <= rts_next;
      dtr_reg      <= dtr_next;
      go_reg       <= go_next;
      txab_reg     <= txab_next;
      rxacc_reg    <= rxacc_next;
      rxab_reg     <= rxab_next;
      diag_reg     <= diag_next;
      irq_reg      <= irq_next;
      dsr_d_reg    <= dsr_d_next;
      auto_d_reg   <= auto_d_next;
      rx_busy_reg  <= rx_busy_next;
      tmr_reg      <= tmr_next;
      st_reg       <= st_next;
    end
  end

  assign rdata_o         = rdata_reg;
  assign rts_o           = rts_reg;
  assign dtr_o           = dtr_reg;
  assign tx_go_o         = go_reg;
  assign tx_abort_o      = txab_reg;
  assign rx_accept_o     = rxacc_reg;
  assign rx_abort_o      = rxab_reg;
  assign diag_dsr_lost_o = diag_reg;
  assign irq_o           = irq_reg;
endmodule

/* dv/hs_ctrl_checker.sv */
// Port assertions for the handshake controller
`timescale 1ns/10ps
module hs_ctrl_checker (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        dsr_i,
  input wire logic        cts_i,
  input wire logic        rts_o,
  input wire logic        dtr_o,
  input wire logic        tx_req_i,
  input wire logic        tx_last_i,
  input wire logic        tx_go_o,
  input wire logic        tx_abort_o,
  input wire logic        rx_valid_i,
  input wire logic        rx_near_full_i,
  input wire logic        rx_accept_o,
  input wire logic        diag_dsr_lost_o
);
  logic        auto_reg;
  logic [15:0] off_reg;
  // Shadow of automatic mode and release delay
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      auto_reg <= 1'h0;
      off_reg  <= 16'h000A;
    end else if (wr_i && addr_i == 4'h0) begin
      auto_reg <= &wdata_i[1:0];
    end else if (wr_i && addr_i == 4'h6) begin
      off_reg  <= wdata_i;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  property p_rst;
    $rose(rst_n_i) |-> !rts_o && !dtr_o;
  endproperty
  a_rst: assert property (p_rst) else $error("line outputs active after reset");
  property p_half;
    wr_i && addr_i == 4'h0 && wdata_i[1:0] == 2'h1 && !auto_reg |=> $stable(dtr_o) && $stable(rts_o);
  endproperty
  a_half: assert property (p_half) else $error("auto mode without half duplex");
  property p_refuse;
    wr_i && addr_i == 4'h1 && auto_reg |=> $stable(dtr_o);
  endproperty
  a_refuse: assert property (p_refuse) else $error("line write taken in auto mode");
  property p_entry;
    wr_i && addr_i == 4'h0 && &wdata_i[1:0] && !auto_reg |=> ##1 !rts_o && dtr_o;
  endproperty
  a_entry: assert property (p_entry) else $error("wrong levels on auto entry");
  property p_req;
    auto_reg && tx_req_i && !rts_o && dsr_i |=> rts_o;
  endproperty
  a_req: assert property (p_req) else $error("request did not raise rts");
  property p_go;
    $rose(tx_go_o) |-> rts_o && $past(cts_i, 3);
  endproperty
  a_go: assert property (p_go) else $error("send started without cts");
  property p_drop;
    tx_go_o && $fell(cts_i) && !tx_last_i |-> ##[1:6] tx_abort_o;
  endproperty
  a_drop: assert property (p_drop) else $error("cts loss did not abort");
  property p_release;
    tx_go_o && tx_last_i && off_reg inside {[16'h0001:16'h0006]} |=> rts_o [*8] ##[1:1000] !rts_o;
  endproperty
  a_release: assert property (p_release) else $error("rts release timing wrong");
  property p_rx_dsr;
    (auto_reg && !dsr_i) [*4] |=> !rx_accept_o;
  endproperty
  a_rx_dsr: assert property (p_rx_dsr) else $error("accepted without dsr");
  property p_full;
    rx_accept_o |-> $past(rx_valid_i) && !$past(rx_near_full_i);
  endproperty
  a_full: assert property (p_full) else $error("accepted while near full");
  property p_lost;
    auto_reg && $fell(dsr_i) |-> ##[1:5] diag_dsr_lost_o;
  endproperty
  a_lost: assert property (p_lost) else $error("dsr loss not logged");
  c_done: cover property (tx_go_o && tx_last_i);
  c_abort: cover property (tx_abort_o);
  c_diag: cover property (diag_dsr_lost_o);
endmodule

bind hs_ctrl hs_ctrl_checker u_chk (
  .clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .dsr_i, .cts_i, .rts_o, .dtr_o, .tx_req_i,
  .tx_last_i, .tx_go_o, .tx_abort_o, .rx_valid_i, .rx_near_full_i, .rx_accept_o, .diag_dsr_lost_o
);

/* dv/remote_station.sv */
// Remote station: answers rts with cts after a lag
`timescale 1ns/10ps
module remote_station (
  input  wire logic        clk_sys_i,
  input  wire logic        rts_i,
  input  wire logic        dsr_on_i,
  input  wire logic        mute_i,
  input  wire logic [15:0] lag_i,
  output logic             cts_o = 1'h0,
  output logic             dsr_o
);
  logic [15:0] cnt_reg = 16'h0000;
  // Cts only after rts has stood for lag cycles
  always_ff @(posedge clk_sys_i) begin
    cnt_reg <= rts_i ? cnt_reg + 16'h0001 : 16'h0000;
    cts_o   <= rts_i && !mute_i && cnt_reg >= lag_i;
  end
  assign dsr_o = dsr_on_i;
endmodule

/* dv/tb.sv */
// Self-checking bench for the handshake controller
`timescale 1ns/10ps
module tb;
  import hs_pkg::*;
  logic        clk_sys_i = 1'h0;
  logic        rst_n_i = 1'h0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'h0;
  logic        rd_i = 1'h0;
  logic        dcd_i = 1'h0;
  logic        ri_i = 1'h0;
  logic        tx_req_i = 1'h0;
  logic        tx_last_i = 1'h0;
  logic        rx_valid_i = 1'h0;
  logic        rx_near_full_i = 1'h0;
  logic        dsr_on = 1'h0;
  logic        mute = 1'h0;
  logic [15:0] lag = 16'h0000;
  logic [15:0] rdata_o, res;
  logic        dsr_i, cts_i, rts_o, dtr_o, tx_go_o, tx_abort_o, rd_d1;
  logic        rx_accept_o, rx_abort_o, diag_dsr_lost_o, irq_o;
  logic [2:0]  ab_seen = 3'h0;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  int          seed = 11;
  int          n;
  int          failures = 0;
  int          checks = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  hs_ctrl dut (
    .clk_sys_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .dcd_i, .dsr_i, .cts_i,
    .ri_i, .rts_o, .dtr_o, .tx_req_i, .tx_last_i, .tx_go_o, .tx_abort_o, .rx_valid_i,
    .rx_near_full_i, .rx_accept_o, .rx_abort_o, .diag_dsr_lost_o, .irq_o
  );
  remote_station partner (
    .clk_sys_i, .rts_i(rts_o), .dsr_on_i(dsr_on), .mute_i(mute), .lag_i(lag), .cts_o(cts_i),
    .dsr_o(dsr_i)
  );
  // Result word: irq, rx accept, DSR-lost and abort pulses seen since last read, read data
  always @(posedge clk_sys_i) begin
    rd_d1 <= rd_i;
    ab_seen <= (rd_d1 === 1'h1 ? 3'h0 : ab_seen)
               | {diag_dsr_lost_o === 1'h1, rx_abort_o === 1'h1, tx_abort_o === 1'h1};
    if (rd_d1 === 1'h1) begin
      res = {irq_o, rx_accept_o, ab_seen, rdata_o[10:0]} & msk_q.pop_front();
      checks++;
      if (res !== exp_q[0]) begin
        failures++;
        $display("wrong value at %0t: got %h, expected %h", $time, res, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'h1;
    @(posedge clk_sys_i);
    wr_i    <= 1'h0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    addr_i <= a;
    rd_i   <= 1'h1;
    @(posedge clk_sys_i);
    rd_i   <= 1'h0;
    @(posedge clk_sys_i);
  endtask
  function automatic logic [15:0] st(input tx_state_t s, input logic r, input logic d);
    return {5'h00, s, ri_i, 1'h0, r, dsr_on, d, dcd_i};
  endfunction
  task automatic run_tx(input logic [15:0] l, input logic [1:0] how,
                        input logic [15:0] e, input logic [15:0] m);
    lag      <= l;
    tx_req_i <= 1'h1;
    @(posedge clk_sys_i);
    tx_req_i <= 1'h0;
    rd(4'h2, st(ST_WAIT, 1'h1, 1'h1), 16'h07EF);
    for (n = 0; n < 2000 && tx_go_o !== 1'h1 && rts_o !== 1'h0; n++) @(posedge clk_sys_i);
    if (how == 2'h1) tx_last_i <= 1'h1;
    if (how == 2'h2) mute <= 1'h1;
    if (how == 2'h3) dsr_on <= 1'h0;
    @(posedge clk_sys_i);
    tx_last_i <= 1'h0;
    for (n = 0; n < 2000 && rts_o !== 1'h0; n++) @(posedge clk_sys_i);
    rd(4'h3, e, m);
    mute   <= 1'h0;
    dsr_on <= 1'h1;
    wr(4'h3, 16'h001F);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    @(posedge clk_sys_i);
    rd(4'h2, st(ST_MAN, 1'h0, 1'h0), 16'h07EF);
    rd(4'h1, 16'h0000, 16'hFFFF);
    rd(4'hB, 16'h0000, 16'hFFFF);
    for (int f = 0; f < 4; f++) begin
      dcd_i <= 1'($random(seed));
      ri_i  <= 1'($random(seed));
      wr(4'h0, 16'h0010 | 16'(f << 2));
      wr(4'h1, 16'h000F);
      rd(4'h2, st(ST_MAN, f < 2, f != 3), 16'h07EF);
      wr(4'h1, 16'h000C);
    end
    wr(4'h0, 16'h0001);
    rd(4'h2, st(ST_MAN, 1'h0, 1'h0), 16'h07EF);
    dsr_on <= 1'h1;
    wr(4'h5, 16'h0002);
    wr(4'h6, 16'h0002);
    wr(4'h4, 16'h001F);
    wr(4'h0, 16'h0013);
    wr(4'h3, 16'h001F);
    rd(4'h2, st(ST_IDLE, 1'h0, 1'h1), 16'h07EF);
    wr(4'h1, 16'h000A);
    rd(4'h3, 16'h8008, 16'h801F);
    wr(4'h3, 16'h001F);
    rx_valid_i <= 1'h1;
    rd(4'h2, 16'h4000, 16'h4000);
    rx_near_full_i <= 1'h1;
    rd(4'h2, 16'h0000, 16'h4000);
    rx_near_full_i <= 1'h0;
    wr(4'h3, 16'h001F);
    run_tx(16'($random(seed)) & 16'h003F, 2'h1, 16'h8001, 16'hB81F);
    run_tx(16'h0FFF, 2'h0, 16'h8802, 16'hB81F);
    run_tx(16'h0008, 2'h2, 16'h8802, 16'hB81F);
    run_tx(16'h0008, 2'h3, 16'hB804, 16'hF804);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    give_verdict();
  end
endmodule
